// >>> adcsp_params.svh
// Purpose: timing counts, field positions and reset values of the serial port
// Assumes: 50 MHz core clock
// Notes: definitions only
`ifndef ADCSP_PARAMS_SVH
`define ADCSP_PARAMS_SVH
`define ADCSP_WORD_BITS 32
`define ADCSP_PREFIX_BITS 3
`define ADCSP_PREFIX_UPDATE 3'h5
`define ADCSP_CMD_BITS 13
`define ADCSP_CHAN_RST 5'h00
`define ADCSP_SPEED_RST 5'h00
`define ADCSP_OSR_RST 16'h0100
`define ADCSP_TWO_X_BIT 4
`define ADCSP_SCK_HALF 6'h04
`define ADCSP_CONV_CYCLES 16'h0100
`endif

// >>> adcsp_pkg.sv
// Purpose: shared types of the serial port
// Assumes: nothing
// Notes: constants live in adcsp_params.svh
package adcsp_pkg;
  typedef enum logic [1:0] {ADCSP_CONVERT, ADCSP_SLEEP, ADCSP_OUTPUT} adcsp_state_e;
  typedef logic [31:0] adcsp_word_t;
endpackage : adcsp_pkg

// >>> adcsp_sync_if.sv
// Purpose: carrier for synchronised pin levels
// Assumes: one core clock
// Notes: driven by the sync module, read by the top
`timescale 1ns/1ps
interface adcsp_sync_if;
  logic cs_n;
  logic sck;
  logic serial_in;
  logic strap_n;
  modport src (output cs_n, output sck, output serial_in, output strap_n);
  modport dst (input cs_n, input sck, input serial_in, input strap_n);
endinterface : adcsp_sync_if

// >>> adcsp_sync.sv
// Purpose: two-flop synchronisers for the pin inputs
// Assumes: pins asynchronous to clk_in
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module adcsp_sync (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic [3:0] pins_in,
  adcsp_sync_if.src sync_out
);
  logic [3:0] meta_q;
  logic [3:0] sync_q;
  // cs resets high (deselected), others low
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      meta_q <= 4'h1;
      sync_q <= 4'h1;
    end
    else if (ce_in)
    begin
      meta_q <= pins_in;
      sync_q <= meta_q;
    end
  end
  assign sync_out.cs_n = sync_q[0];
  assign sync_out.sck = sync_q[1];
  assign sync_out.serial_in = sync_q[2];
  assign sync_out.strap_n = sync_q[3];
endmodule : adcsp_sync

// >>> adcsp_port.sv
// Purpose: serial port, conversion sequencing and mux select of a delta-sigma converter
// Assumes: pins sampled by clk_in; modulator outside, result given on result_in
// Notes: internal clock mode drives the serial clock from a divider of clk_in
`timescale 1ns/1ps
`include "adcsp_params.svh"

//////////////////////////////////////////////////////////////////////////////
module adcsp_port (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic chip_select_n_in,
  input wire logic sck_in,
  input wire logic serial_in_in,
  input wire logic clock_source_strap_n_in,
  input wire logic [28:0] result_in,
  input wire logic over_range_in,
  input wire logic under_range_in,
  output logic serial_out_out,
  output logic serial_out_oe_out,
  output logic sck_out,
  output logic sck_oe_out,
  output logic [3:0] pos_chan_out,
  output logic [3:0] neg_chan_out,
  output logic common_negative_input_out,
  output logic [4:0] speed_code_out,
  output logic two_x_mode_out,
  output logic conv_start_out,
  output logic converting_out
);
  import adcsp_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // synchronised pins
  adcsp_sync_if sync_bus ();
  adcsp_sync u_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .ce_in(ce_in),
    .pins_in({clock_source_strap_n_in, serial_in_in, sck_in, chip_select_n_in}),
    .sync_out(sync_bus)
  );

  adcsp_state_e state_q, state_d;
  logic cs_n_q;
  logic ext_sck_q;
  logic int_sck_q;
  logic [5:0] div_q;
  logic [5:0] bit_cnt_q;
  adcsp_word_t shift_q;
  logic [12:0] cmd_q;
  logic [15:0] conv_cnt_q;
  logic [4:0] chan_q;
  logic [4:0] speed_q;
  logic sdo_q;
  logic oe_q;
  logic start_q;
  logic strap_q;
  logic strap_valid_q;
  logic [1:0] strap_wait_q;
  adcsp_word_t held_word_q;

  //////////////////////////////////////////////////////////////////////////////
  // edge detection on the selected serial clock source
  wire internal_mode = strap_q;
  wire cur_sck = internal_mode ? int_sck_q : sync_bus.sck;
  logic prev_sck_q;
  wire sck_rise = cur_sck & ~prev_sck_q;
  wire sck_fall = ~cur_sck & prev_sck_q;
  wire cs_low = ~sync_bus.cs_n;
  wire cs_rise = sync_bus.cs_n & ~cs_n_q;
  wire conv_done = (conv_cnt_q == 16'h0001);
  wire [4:0] next_chan = cmd_q[9:5];
  wire [4:0] next_speed = cmd_q[4:0];
  wire cmd_update = (cmd_q[12:10] == `ADCSP_PREFIX_UPDATE);
  wire last_fall = sck_fall && (bit_cnt_q == 6'(`ADCSP_WORD_BITS));
  wire abort = (state_q == ADCSP_OUTPUT) && cs_rise;
  wire end_output = abort || last_fall;
  wire div_wrap = (div_q == `ADCSP_SCK_HALF - 6'h01);

  //////////////////////////////////////////////////////////////////////////////
  // result word assembly; in range the sign is the inverse of the offset-form MSB
  adcsp_word_t conv_word;
  always_comb
  begin
    conv_word = {2'b00, ~result_in[28], result_in};
    if (over_range_in)
      conv_word = {3'b001, 1'b1, 28'h0000000};
    else if (under_range_in)
      conv_word = {3'b000, 1'b0, 28'hfffffff};
  end

  //////////////////////////////////////////////////////////////////////////////
  // state machine
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ADCSP_CONVERT:
        if (conv_done)
          state_d = ADCSP_SLEEP;
      ADCSP_SLEEP:
        if (cs_low && sck_rise)
          state_d = ADCSP_OUTPUT;
      ADCSP_OUTPUT:
        if (end_output)
          state_d = ADCSP_CONVERT;
      default:
        state_d = ADCSP_CONVERT;
    endcase
  end

  // strap caught after reset release, once the sync flops hold the pin level
  // rather than their own reset value
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      strap_q <= 1'b0;
      strap_valid_q <= 1'b0;
      strap_wait_q <= 2'h0;
    end
    else if (ce_in && !strap_valid_q)
    begin
      strap_q <= sync_bus.strap_n;
      strap_wait_q <= strap_wait_q + 2'h1;
      strap_valid_q <= (strap_wait_q == 2'h2);
    end
  end

  // state and edge history
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state_q <= ADCSP_CONVERT;
      cs_n_q <= 1'b1;
      prev_sck_q <= 1'b0;
      ext_sck_q <= 1'b0;
    end
    else if (ce_in)
    begin
      state_q <= state_d;
      cs_n_q <= sync_bus.cs_n;
      prev_sck_q <= cur_sck;
      ext_sck_q <= sync_bus.sck;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // internal serial clock divider; runs only while selected and outside the convert state
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      div_q <= 6'h00;
      int_sck_q <= 1'b0;
    end
    else if (ce_in)
    begin
      if (internal_mode && cs_low && state_q != ADCSP_CONVERT && !end_output)
      begin
        div_q <= div_wrap ? 6'h00 : div_q + 6'h01;
        if (div_wrap)
          int_sck_q <= ~int_sck_q;
      end
      else
      begin
        div_q <= 6'h00;
        int_sck_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // conversion timer; 2X halves the cycle, the modulator itself is outside
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      conv_cnt_q <= `ADCSP_CONV_CYCLES;
      start_q <= 1'b0;
    end
    else if (ce_in)
    begin
      start_q <= (state_q == ADCSP_OUTPUT) && end_output;
      if (state_q == ADCSP_OUTPUT && end_output)
        conv_cnt_q <= speed_q[`ADCSP_TWO_X_BIT] ?
          (`ADCSP_CONV_CYCLES >> 1) : `ADCSP_CONV_CYCLES;
      else if (state_q == ADCSP_CONVERT && !conv_done)
        conv_cnt_q <= conv_cnt_q - 16'h0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // result capture; 2X delivers the word of the conversion before last
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      held_word_q <= 32'h00000000;
    else if (ce_in && state_q == ADCSP_CONVERT && conv_done)
      held_word_q <= conv_word;
  end

  wire [31:0] load_word = speed_q[`ADCSP_TWO_X_BIT] ? held_word_q : conv_word;

  //////////////////////////////////////////////////////////////////////////////
  // shift engine: output on falling edges, input sampled on rising edges
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      shift_q <= 32'h00000000;
      bit_cnt_q <= 6'h00;
      cmd_q <= 13'h0000;
    end
    else if (ce_in)
    begin
      if (state_q == ADCSP_CONVERT && conv_done)
      begin
        shift_q <= load_word;
        bit_cnt_q <= 6'h00;
        cmd_q <= 13'h0000;
      end
      else if (state_q != ADCSP_CONVERT && cs_low)
      begin
        if (sck_rise && bit_cnt_q < 6'(`ADCSP_CMD_BITS))
          cmd_q <= {cmd_q[11:0], sync_bus.serial_in};
        if (sck_rise)
          bit_cnt_q <= bit_cnt_q + 6'h01;
        if (sck_fall)
          shift_q <= {shift_q[30:0], 1'b1};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // channel and speed latch, applied when the next conversion starts
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      chan_q <= `ADCSP_CHAN_RST;
      speed_q <= `ADCSP_SPEED_RST;
    end
    else if (ce_in && state_q == ADCSP_OUTPUT && end_output
             && bit_cnt_q >= 6'(`ADCSP_CMD_BITS) && cmd_update)
    begin
      chan_q <= next_chan;
      if (next_speed != 5'h00)
        speed_q <= next_speed;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // mux decode from address {single, polarity, a2, a1, a0}
  wire single = chan_q[4];
  wire polarity = chan_q[3];
  wire [2:0] pair = chan_q[2:0];
  wire [3:0] even_ch = {pair, 1'b0};
  wire [3:0] odd_ch = {pair, 1'b1};
  wire [3:0] pos_d = (polarity ? odd_ch : even_ch);
  wire [3:0] neg_d = single ? 4'h0 : (polarity ? even_ch : odd_ch);

  //////////////////////////////////////////////////////////////////////////////
  // pin and status outputs, all registered
  wire sdo_d = (state_q == ADCSP_OUTPUT) ? (last_fall ? 1'b1 : shift_q[31])
             : (state_q == ADCSP_CONVERT);
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sdo_q <= 1'b1;
      oe_q <= 1'b0;
      serial_out_out <= 1'b1;
      serial_out_oe_out <= 1'b0;
      sck_out <= 1'b0;
      sck_oe_out <= 1'b0;
      pos_chan_out <= 4'h0;
      neg_chan_out <= 4'h1;
      common_negative_input_out <= 1'b0;
      speed_code_out <= 5'h00;
      two_x_mode_out <= 1'b0;
      conv_start_out <= 1'b0;
      converting_out <= 1'b1;
    end
    else if (ce_in)
    begin
      sdo_q <= sdo_d;
      oe_q <= cs_low;
      serial_out_out <= sdo_d;
      serial_out_oe_out <= cs_low;
      sck_out <= int_sck_q;
      sck_oe_out <= internal_mode;
      pos_chan_out <= pos_d;
      neg_chan_out <= neg_d;
      common_negative_input_out <= single;
      speed_code_out <= speed_q;
      two_x_mode_out <= speed_q[`ADCSP_TWO_X_BIT];
      conv_start_out <= start_q;
      converting_out <= (state_d == ADCSP_CONVERT);
    end
  end
endmodule : adcsp_port

// >>> adcsp_port_asserts.sv
// Purpose: port-level checks of the converter serial port
// Assumes: external serial clock period of 8 core clocks or more
// Notes: bound to adcsp_port at the foot of this file
`timescale 1ns/1ps
module adcsp_port_asserts (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic chip_select_n_in,
  input wire logic clock_source_strap_n_in,
  input wire logic serial_out_out,
  input wire logic serial_out_oe_out,
  input wire logic sck_oe_out,
  input wire logic [3:0] pos_chan_out,
  input wire logic [3:0] neg_chan_out,
  input wire logic [4:0] speed_code_out,
  input wire logic conv_start_out,
  input wire logic converting_out
);
  // one domain; the pins pass sync flops, hence the slack of a few cycles
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  ////////////////////////////////////////
  oe_off_a: assert property (chip_select_n_in [*5] |-> !serial_out_oe_out)
    else $error("data output driven while deselected");
  oe_on_a: assert property ((!chip_select_n_in) [*5] |-> serial_out_oe_out)
    else $error("data output idle while selected");
  pend_flag_a: assert property (converting_out && serial_out_oe_out |-> serial_out_out)
    else $error("pending flag low during conversion");
  strap_int_a: assert property (clock_source_strap_n_in [*8] |-> sck_oe_out)
    else $error("serial clock not driven with strap high");
  strap_ext_a: assert property ((!clock_source_strap_n_in) [*8] |-> !sck_oe_out)
    else $error("serial clock driven with strap low");
  start_pulse_a: assert property (conv_start_out |=> !conv_start_out && converting_out)
    else $error("start pulse too long or no conversion");
  conv_len_a: assert property ($rose(conv_start_out) |-> ##[126:258] $fell(converting_out))
    else $error("conversion did not end in time");
  mux_hold_a: assert property ($changed({pos_chan_out, neg_chan_out, speed_code_out})
    |-> conv_start_out || $past(conv_start_out))
    else $error("selection changed outside conversion start");
  diff_pair_a: assert property (neg_chan_out != 4'h0 |-> neg_chan_out == (pos_chan_out ^ 4'h1))
    else $error("differential pair not adjacent");
endmodule : adcsp_port_asserts

bind adcsp_port adcsp_port_asserts i_chk (.*);

// >>> adcsp_host.sv
// Purpose: behavioural serial controller facing the converter
// Assumes: external clock mode, 160 ns serial clock period
// Notes: samples data late in the high phase, well after the update
`timescale 1ns/1ps
module adcsp_host (
  input wire logic sdo_in,
  output logic cs_n_out,
  output logic sck_out,
  output logic sdi_out
);
  logic [31:0] word_q;
  logic tail_q;
  event done;
  // deselected, clock parked low between frames
  initial
  begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    sdi_out = 1'b0;
  end
  // select and return the status level after the sync delay
  task automatic poll(output logic s);
    cs_n_out = 1'b0;
    #200 s = sdo_in;
  endtask : poll
  // frame of nfall clocks; fewer than 32 aborts by deselecting
  task automatic xfer(input logic [12:0] cmd, input int nfall);
    cs_n_out = 1'b0;
    #207;
    for (int k = 0; k < nfall; k++)
    begin
      sdi_out = (k < 13) ? cmd[12 - k] : k[0];
      #80 sck_out = 1'b1;
      #79 word_q = {word_q[30:0], sdo_in};
      #1 sck_out = 1'b0;
    end
    #200 tail_q = sdo_in;
    cs_n_out = 1'b1;
    sdi_out = ~sdi_out;
    if (nfall == 32)
      -> done;
    #200;
  endtask : xfer
endmodule : adcsp_host

// >>> tb_adc_serial_port_and_mux_select.sv
// Purpose: self-checking bench of the converter serial port
// Assumes: external clock mode, internal mode only checked at the end
// Notes: drivers queue notes, watchers compare when results show
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin n_checks++; if ((e) !== (g)) begin miscompares++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_adc_serial_port_and_mux_select;
  import adcsp_pkg::*;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic strap_n = 1'b0;
  logic [28:0] res_in = 29'h0;
  logic ovr = 1'b0;
  logic und = 1'b0;
  wire cs_n, sck_h, serial_in;
  logic sdo_oe, serial_out, sck_d, sck_oe, common_negative_input, twox, cstart, conv, s;
  logic [3:0] pos, neg;
  logic [4:0] spd;
  wire sdo_w = sdo_oe ? serial_out : 1'bz;
  wire sck_w = sck_oe ? sck_d : sck_h;
  int miscompares = 0;
  int n_checks = 0;
  logic [32:0] exp_w[$];
  logic [14:0] exp_m[$];
  logic [32:0] e, cur_n, prev_n;
  logic [4:0] chan_e = 5'h00;
  logic [4:0] spd_e = 5'h00;
  logic [12:0] cmd;
  adcsp_word_t r;
  logic [12:0] cmds [8] = '{13'h1463, 13'h17a0, 13'h13ff, 13'h02ab,
    13'h1553, 13'h1553, 13'h1401, 13'h0000};
  int nf [8] = '{32, 32, 32, 32, 10, 32, 32, 32};
  adcsp_port i_dut (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .ce_in(1'b1),
    .chip_select_n_in(cs_n),
    .sck_in(sck_w),
    .serial_in_in(serial_in),
    .clock_source_strap_n_in(strap_n),
    .result_in(res_in),
    .over_range_in(ovr),
    .under_range_in(und),
    .serial_out_out(serial_out),
    .serial_out_oe_out(sdo_oe),
    .sck_out(sck_d),
    .sck_oe_out(sck_oe),
    .pos_chan_out(pos),
    .neg_chan_out(neg),
    .common_negative_input_out(common_negative_input),
    .speed_code_out(spd),
    .two_x_mode_out(twox),
    .conv_start_out(cstart),
    .converting_out(conv)
  );
  adcsp_host i_host (
    .sdo_in(sdo_w),
    .cs_n_out(cs_n),
    .sck_out(sck_h),
    .sdi_out(serial_in)
  );
  ////////////////////////////////////////
  // expected selection: pair n is 2n/2n+1, single-ended against common
  function automatic logic [14:0] mux_note(logic [4:0] c, logic [4:0] sp);
    logic [3:0] p;
    p = {c[2:0], c[3]};
    return {p, c[4] ? 4'h0 : p ^ 4'h1, c[4], sp, sp[4]};
  endfunction : mux_note
  // word note; in range the sign is the inverse of the offset-form MSB, bit 32 flags clamps
  function automatic logic [32:0] word_note(logic [28:0] v, logic o, logic u);
    return {o | u, 2'b00, o ? {2'b11, 28'h0} : u ? {2'b00, 28'hfffffff} : {~v[28], v}};
  endfunction : word_note
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up
  // bounded wait for the end of a conversion
  task automatic wait_sleep();
    for (int n = 0; n < 600 && conv !== 1'b0; n++)
      @(posedge clk_in);
    if (conv !== 1'b0)
    begin
      miscompares++;
      wrap_up();
    end
    repeat (3) @(posedge clk_in);
  endtask : wait_sleep
  ////////////////////////////////////////
  initial
  begin
    forever #10 clk_in = ~clk_in;
  end
  // compare each full 32-clock frame read by the host with the oldest note
  initial
  forever
  begin
    @(i_host.done);
    e = exp_w.pop_front();
    `CHK("word", e[31:0], i_host.word_q)
    `CHK("tail", 1'b1, i_host.tail_q)
  end
  // compare the selection two cycles after each conversion start
  initial
  forever
  begin
    @(posedge cstart);
    repeat (2) @(posedge clk_in);
    `CHK("mux", exp_m.pop_front(), {pos, neg, common_negative_input, spd, twox})
  end
  // main sequence
  initial
  begin
    void'($urandom(61023));
    cur_n = word_note(29'h0, 1'b0, 1'b0);
    prev_n = cur_n;
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    `CHK("reset mux", mux_note(5'h00, 5'h00), {pos, neg, common_negative_input, spd, twox})
    `CHK("reset oe", 1'b0, sdo_oe)
    i_host.poll(s);
    `CHK("busy flag", 1'b1, s)
    wait_sleep();
    `CHK("done flag", 1'b0, sdo_w)
    `CHK("external clock", 1'b0, sck_oe)
    for (int i = 0; i < 8; i++)
    begin
      cmd = cmds[i];
      if (i == 6)
        cmd[9:5] = 5'($urandom);
      if (nf[i] == 32)
        exp_w.push_back(spd_e[4] ? prev_n : cur_n);
      if (cmd[12:10] == 3'b101 && nf[i] == 32)
      begin
        chan_e = cmd[9:5];
        spd_e = (cmd[4:0] == 5'h00) ? spd_e : cmd[4:0];
      end
      exp_m.push_back(mux_note(chan_e, spd_e));
      i_host.xfer(cmd, nf[i]);
      r = $urandom;
      prev_n = cur_n;
      cur_n = word_note(r[28:0], i == 1, i == 2);
      @(posedge clk_in);
      res_in <= r[28:0];
      ovr <= (i == 1);
      und <= (i == 2);
      wait_sleep();
    end
    rst_b_in <= 1'b0;
    strap_n <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (10) @(posedge clk_in);
    `CHK("internal clock", 1'b1, sck_oe)
    `CHK("parked clock", 1'b0, sck_d)
    wrap_up();
  end
endmodule : tb_adc_serial_port_and_mux_select
